// ===== hdl/tws_slave.sv
// three-wire serial control slave with write checksum and status register
// assumes sck, en and sdio arrive asynchronously to CORE_CLK and sck is far slower
`timescale 1ns/10ps
`include "tws_defines.svh"
// Notes on behaviour
// - status bits 5 and 4 show battery-low flags, reset 0, invalid in standby.
// - error flags at bits 0,1,2 clear on write of one; brownout resets to 1.
// - command spans enable high; bus ignored while enable is low.
// - data line shared; device drives only while returning read data.
// - clock low at enable rise: sample on falling, launch on rising edge.
// - clock high at enable rise: sample on rising, launch on falling edge.
// - edge choice latched at enable rise and held until enable falls.
// - burst write keeps enable high; address increments after each data byte.
// - on writes every complete byte, command included, is XORed into checksum.
// - reading checksum returns its value and then clears it.
// - reading other registers leaves the checksum unchanged.
// - first byte is command: top two bits function, low six bits address.
module tws_slave
  import tws_pkg::*;
#(
  parameter int CFG_DEPTH = 36
)(
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic       SCK,
  input  wire logic       EN,
  input  wire logic       SDIO_IN,
  output logic            SDIO_OUT,
  output logic            SDIO_OE_N,
  input  wire logic       STANDBY,
  input  wire logic       LOCK_ERR_EVT,
  input  wire logic       PARITY_ERR_EVT,
  input  wire logic       BROWNOUT_EVT,
  input  wire logic       SUPPLY_FAIL,
  input  wire logic       BATT_LOW_UPPER,
  input  wire logic       BATT_LOW_LOWER,
  output logic [1:0]      TX_CMD_STB,
  output logic [5:0]      TX_CMD_PARAM
);
  logic            sck_s;
  logic            en_s;
  logic            sdio_s;
  logic            sck_d;
  logic            en_d;
  logic            edge_hi;
  tws_edge_s       ev;
  tws_state_e      state;
  logic [2:0]      bit_cnt;
  logic [7:0]      shreg;
  logic [7:0]      txreg;
  logic [5:0]      addr;
  logic [7:0]      checksum;
  logic            lock_loss_flag;
  logic            parity_error_flag;
  logic            brownout_flag;
  logic [7:0]      cfg [0:CFG_DEPTH-1];
  logic [7:0]      byte_in;
  logic            byte_done;
  logic            en_rise;
  logic            en_fall;
  logic            active;
  logic [7:0]      status_view;
  logic [7:0]      read_data;
  logic [5:0]      cfg_index;
  logic [5:0]      rd_index;
  logic            status_wr;
  logic            cfg_wr;

  // ============================================================
  // pin synchronisers
  tws_sync u_sync_sck  (.clk(CORE_CLK), .rst(RST), .d(SCK),     .q(sck_s));
  tws_sync u_sync_en   (.clk(CORE_CLK), .rst(RST), .d(EN),      .q(en_s));
  tws_sync u_sync_sdio (.clk(CORE_CLK), .rst(RST), .d(SDIO_IN), .q(sdio_s));

  // delayed copies for edge detection
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sck_d <= 1'b0;
      en_d  <= 1'b0;
    end else begin
      sck_d <= sck_s;
      en_d  <= en_s;
    end
  end

  assign en_rise = en_s & ~en_d;
  assign en_fall = ~en_s & en_d;
  assign active  = en_s & en_d;                    // bus ignored otherwise

  // ============================================================
  // active edge selection, held for the whole frame
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      edge_hi <= 1'b0;
    end else if (en_rise) begin
      edge_hi <= sck_s;
    end
  end

  // sample and launch strobes per latched polarity
  always_comb begin
    ev.sample = 1'b0;
    ev.launch = 1'b0;
    if (active) begin
      if (edge_hi) begin
        ev.sample = sck_s & ~sck_d;
        ev.launch = ~sck_s & sck_d;
      end else begin
        ev.sample = ~sck_s & sck_d;
        ev.launch = sck_s & ~sck_d;
      end
    end
  end

  // ============================================================
  // bit shifter, msb first
  assign byte_in   = {shreg[6:0], sdio_s};
  assign byte_done = ev.sample && (bit_cnt == 3'h7);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      shreg   <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (!en_s) begin
      bit_cnt <= 3'h0;                             // partial byte dropped at frame end
    end else if (ev.sample) begin
      shreg   <= byte_in;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // ============================================================
  // command sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state        <= TWS_ST_IDLE;
      addr         <= 6'h00;
      TX_CMD_STB   <= 2'h0;
      TX_CMD_PARAM <= 6'h00;
    end else begin
      TX_CMD_STB <= 2'h0;
      if (!en_s) begin
        state <= TWS_ST_IDLE;
      end else if (en_rise) begin
        state <= TWS_ST_CMD;
      end else if (byte_done) begin
        case (state)
          TWS_ST_CMD: begin
            addr <= byte_in[5:0];
            case (byte_in[7:6])
              `TWS_FN_WRITE: state <= TWS_ST_WDATA;
              `TWS_FN_READ:  state <= TWS_ST_RDATA;
              `TWS_FN_TX: begin
                state        <= TWS_ST_IDLE;
                TX_CMD_STB   <= 2'h1;
                TX_CMD_PARAM <= byte_in[5:0];
              end
              default:       state <= TWS_ST_IDLE; // reserved code ignored
            endcase
          end
          TWS_ST_WDATA: addr <= addr + 6'h01;      // burst auto-increment
          TWS_ST_RDATA: addr <= addr;
          default:      state <= TWS_ST_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // configuration store; host keeps writes in range
  assign status_wr = byte_done && (state == TWS_ST_WDATA) && (addr == `TWS_ADDR_STATUS);
  assign cfg_index = 6'(addr - `TWS_ADDR_CFG_LO);
  assign cfg_wr    = byte_done && (state == TWS_ST_WDATA) && (addr >= `TWS_ADDR_CFG_LO)
                     && (addr <= `TWS_ADDR_CFG_HI);

  always_ff @(posedge CORE_CLK) begin
    if (cfg_wr) begin
      cfg[cfg_index] <= byte_in;
    end
  end

  // ============================================================
  // error flags: hardware set wins over host clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lock_loss_flag    <= 1'b0;
      parity_error_flag <= 1'b0;
      brownout_flag     <= 1'b1;
    end else begin
      lock_loss_flag    <= LOCK_ERR_EVT   | (lock_loss_flag    & ~(status_wr & byte_in[`TWS_BIT_LOCK]));
      parity_error_flag <= PARITY_ERR_EVT | (parity_error_flag & ~(status_wr & byte_in[`TWS_BIT_PARITY]));
      brownout_flag     <= BROWNOUT_EVT   | (brownout_flag     & ~(status_wr & byte_in[`TWS_BIT_BROWNOUT]));
    end
  end

  // battery flags forced low in standby where they carry no meaning
  always_comb begin
    status_view                      = `TWS_STATUS_RESET & 8'h80;
    status_view[`TWS_BIT_BATT_LOWER] = BATT_LOW_LOWER & ~STANDBY;
    status_view[`TWS_BIT_BATT_UPPER] = BATT_LOW_UPPER & ~STANDBY;
    status_view[`TWS_BIT_SUPPLY]     = SUPPLY_FAIL;
    status_view[`TWS_BIT_BROWNOUT]   = brownout_flag;
    status_view[`TWS_BIT_PARITY]     = parity_error_flag;
    status_view[`TWS_BIT_LOCK]       = lock_loss_flag;
  end

  // read mux on the address completing in the command byte, so the value is ready before the first launch edge
  assign rd_index = 6'(byte_in[5:0] - `TWS_ADDR_CFG_LO);

  always_comb begin
    if (byte_in[5:0] == `TWS_ADDR_CHECKSUM) begin
      read_data = checksum;
    end else if (byte_in[5:0] == `TWS_ADDR_STATUS) begin
      read_data = status_view;
    end else if ((byte_in[5:0] >= `TWS_ADDR_CFG_LO) && (byte_in[5:0] <= `TWS_ADDR_CFG_HI)) begin
      read_data = cfg[rd_index];
    end else begin
      read_data = 8'h00;
    end
  end

  // ============================================================
  // checksum: XOR of every write byte, cleared once read
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      checksum <= `TWS_CHECKSUM_RESET;
    end else if (byte_done && ((state == TWS_ST_WDATA) ||
                 ((state == TWS_ST_CMD) && (byte_in[7:6] == `TWS_FN_WRITE)))) begin
      checksum <= checksum ^ byte_in;
    end else if (byte_done && (state == TWS_ST_RDATA) && (addr == `TWS_ADDR_CHECKSUM)) begin
      checksum <= 8'h00;                           // clear after the byte went out
    end
  end

  // ============================================================
  // read output: loaded when the read command completes, then shifted on launch edges
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      txreg     <= 8'h00;
      SDIO_OUT  <= 1'b0;
      SDIO_OE_N <= 1'b1;
    end else if (!en_s) begin
      SDIO_OE_N <= 1'b1;                           // release line with frame
    end else if (byte_done && (state == TWS_ST_CMD) && (byte_in[7:6] == `TWS_FN_READ)) begin
      txreg <= read_data;
    end else if (ev.launch && (state == TWS_ST_RDATA)) begin
      SDIO_OE_N <= 1'b0;                           // drive only for read data
      SDIO_OUT  <= txreg[7];
      txreg     <= {txreg[6:0], 1'b0};
    end
  end

endmodule

// ===== hdl/tws_defines.svh
// constants for the three-wire serial control slave
// assumes inclusion by hdl files only
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// ============================================================
// register map
`define TWS_ADDR_CHECKSUM   6'h00
`define TWS_ADDR_STATUS     6'h01
`define TWS_ADDR_CFG_LO     6'h04
`define TWS_ADDR_CFG_HI     6'h27
// ============================================================
// status bit positions
`define TWS_BIT_LOCK        0
`define TWS_BIT_PARITY      1
`define TWS_BIT_BROWNOUT    2
`define TWS_BIT_SUPPLY      3
`define TWS_BIT_BATT_UPPER  4
`define TWS_BIT_BATT_LOWER  5
`define TWS_BIT_MANDATORY   7
// ============================================================
// reset values
`define TWS_STATUS_RESET    8'h84
`define TWS_CHECKSUM_RESET  8'h00
// ============================================================
// function codes
`define TWS_FN_WRITE        2'h0
`define TWS_FN_READ         2'h1
`define TWS_FN_RSVD         2'h2
`define TWS_FN_TX           2'h3
`endif

// ===== hdl/tws_pkg.sv
// types shared by the three-wire serial control slave
// assumes tws_defines.svh for numeric constants
package tws_pkg;
  // ============================================================
  // command phase
  typedef enum logic [1:0] {
    TWS_ST_IDLE  = 2'b00,
    TWS_ST_CMD   = 2'b01,
    TWS_ST_WDATA = 2'b10,
    TWS_ST_RDATA = 2'b11
  } tws_state_e;

  // decoded command byte
  typedef struct packed {
    logic [1:0] func;
    logic [5:0] addr;
  } tws_cmd_s;

  // events found on the serial clock
  typedef struct packed {
    logic sample;
    logic launch;
  } tws_edge_s;
endpackage

// ===== hdl/tws_sync.sv
// two flip-flop synchroniser for one asynchronous level
// assumes CORE_CLK domain and asynchronous active-high reset
`timescale 1ns/10ps
module tws_sync
  import tws_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // ============================================================
  // first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== verification/tws_slave_chk.sv
// port checker for the serial control slave
// assumes it is bound onto tws_slave and sees only its ports
`timescale 1ns/10ps
module tws_slave_chk
  import tws_pkg::*;
#(
  parameter int CFG_DEPTH = 36
)(
  input wire logic       CORE_CLK,
  input wire logic       RST,
  input wire logic       SCK,
  input wire logic       EN,
  input wire logic       SDIO_OUT,
  input wire logic       SDIO_OE_N,
  input wire logic [1:0] TX_CMD_STB,
  input wire logic [5:0] TX_CMD_PARAM
);
  logic       sck_q;
  logic [3:0] since;
  // ============================================================
  // helper
  // cycles since the clock pin last moved; saturates so it never wraps
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sck_q <= 1'b0;
      since <= 4'hf;
    end else begin
      sck_q <= SCK;
      since <= (SCK != sck_q) ? 4'h0 : ((since == 4'hf) ? since : since + 4'h1);
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ============================================================
  // assertions
  a_oe_idle: assert property (!EN [*6] |-> SDIO_OE_N) else $error("data driven with frame closed");
  a_oe_start: assert property ($fell(SDIO_OE_N) |-> EN) else $error("drive began outside frame");
  a_oe_end: assert property ($rose(SDIO_OE_N) |-> !EN) else $error("drive dropped inside frame");
  a_out_launch: assert property (!SDIO_OE_N && !$past(SDIO_OE_N) && $changed(SDIO_OUT)
    |-> since inside {[1:5]}) else $error("read bit moved off a clock edge");
  a_stb_pulse: assert property (TX_CMD_STB[0] |=> !TX_CMD_STB[0]) else $error("strobe too long");
  a_stb_upper: assert property (!TX_CMD_STB[1]) else $error("upper strobe bit set");
  a_stb_frame: assert property (TX_CMD_STB[0] |-> EN && SDIO_OE_N) else $error("strobe outside frame");
  a_param_cause: assert property ($changed(TX_CMD_PARAM) |-> TX_CMD_STB[0] || $past(TX_CMD_STB[0]))
    else $error("parameter moved without strobe");
endmodule
bind tws_slave tws_slave_chk #(.CFG_DEPTH(CFG_DEPTH)) i_chk (.CORE_CLK(CORE_CLK), .RST(RST), .SCK(SCK),
  .EN(EN), .SDIO_OUT(SDIO_OUT), .SDIO_OE_N(SDIO_OE_N), .TX_CMD_STB(TX_CMD_STB), .TX_CMD_PARAM(TX_CMD_PARAM));

// ===== verification/tws_host.sv
// host model: drives enable, clock and data of the three-wire bus
// assumes the bench resolves the data line with a pull-down
`timescale 1ns/10ps
module tws_host (
  input  wire logic clk,
  input  wire logic sdio,
  output logic      sck,
  output logic      en,
  output logic      host_oe,
  output logic      host_d
);
  initial begin
    {sck, en, host_oe, host_d} = 4'h0;
  end
  // ============================================================
  // one framed command, msb first; read data taken just before the next launch edge
  task automatic frame(input logic pol, input int n, input logic [23:0] w, output logic [7:0] rd);
    logic [23:0] s;
    logic        rdop;
    s = w;
    rd = 8'h00;
    rdop = (w[23:22] == 2'h1);
    @(posedge clk) #2;
    sck = pol;
    #400 en = 1'b1;
    #400;
    for (int i = 0; i < 8 * (n + int'(rdop)); i++) begin
      sck = ~sck;
      host_oe = !(rdop && i >= 8);
      host_d = s[23];
      s = {s[22:0], 1'b0};
      #400 sck = ~sck;
      #400 rd = {rd[6:0], sdio};
    end
    en = 1'b0;
    host_oe = 1'b0;
    #800;
  endtask
  // bus activity with the frame closed
  task automatic noise();
    @(posedge clk) #2;
    host_oe = 1'b1;
    for (int i = 0; i < 16; i++) begin
      sck = ~sck;
      host_d = ~host_d;
      #400;
    end
    host_oe = 1'b0;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the serial control slave
// assumes tws_host drives the pins at an 800 ns bit period
`timescale 1ns/10ps
module testbench;
  import tws_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sck, en, host_oe, host_d, sdio, sdo, oe_n;
  logic       stby = 0, lock = 0, par = 0, brn = 0, sup = 0, bup = 0, blo = 0;
  logic [1:0] stb;
  logic [5:0] prm;
  logic [7:0] sum = 8'h00, v;
  int         failures = 0, n_tests = 0, n_stb = 0;
  // ============================================================
  // pins and instances; pull-down keeps the released line low
  assign sdio = !oe_n ? sdo : (host_oe ? host_d : 1'b0);
  always #50 clk = ~clk;
  always @(posedge clk) if (stb[0]) n_stb++;
  tws_host i_host (.clk(clk), .sdio(sdio), .sck(sck), .en(en), .host_oe(host_oe), .host_d(host_d));
  tws_slave #(.CFG_DEPTH(36)) i_dut (.CORE_CLK(clk), .RST(rst), .SCK(sck), .EN(en), .SDIO_IN(sdio),
    .SDIO_OUT(sdo), .SDIO_OE_N(oe_n), .STANDBY(stby), .LOCK_ERR_EVT(lock), .PARITY_ERR_EVT(par),
    .BROWNOUT_EVT(brn), .SUPPLY_FAIL(sup), .BATT_LOW_UPPER(bup), .BATT_LOW_LOWER(blo),
    .TX_CMD_STB(stb), .TX_CMD_PARAM(prm));
  // ============================================================
  // shared tasks
  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write frame; the expected checksum folds in every byte sent
  task automatic wr(input logic pol, input int n, input logic [23:0] w);
    logic [7:0] d;
    i_host.frame(pol, n, w, d);
    for (int i = 0; i < n; i++) sum ^= w[23 - 8 * i -: 8];
  endtask
  // reading the checksum also clears the expected copy
  task automatic rdreg(input logic pol, input logic [5:0] a, input string nm, input logic [7:0] exp);
    i_host.frame(pol, 1, {2'h1, a, 16'h0000}, v);
    chk(nm, exp, v);
    if (a == 6'h00) sum = 8'h00;
  endtask
  // ============================================================
  // scenarios
  task automatic t_sum();
    rdreg(0, 6'h01, "status", 8'h84);
    rdreg(0, 6'h00, "checksum", 8'h00);
    wr(0, 2, 24'h040200);
    wr(0, 2, 24'h050100);
    rdreg(0, 6'h04, "cfg04", 8'h02);
    rdreg(0, 6'h01, "status", 8'h84);
    rdreg(0, 6'h00, "checksum", 8'h02);
    rdreg(0, 6'h00, "cleared", 8'h00);
  endtask
  task automatic t_burst();
    wr(1, 3, 24'h06a53c);
    rdreg(1, 6'h07, "cfg07", 8'h3c);
    rdreg(1, 6'h06, "cfg06", 8'ha5);
    rdreg(0, 6'h00, "checksum", sum);
  endtask
  task automatic t_status();
    @(posedge clk) #2;
    {lock, par, sup, bup, blo} = 5'h1f;
    @(posedge clk) #2;
    {lock, par} = 2'h0;
    rdreg(0, 6'h01, "status", 8'hbf);
    stby = 1'b1;
    rdreg(0, 6'h01, "standby", 8'h8f);
    wr(0, 2, 24'h018700);
    rdreg(0, 6'h01, "flags", 8'h88);
    @(posedge clk) #2 brn = 1'b1;
    @(posedge clk) #2 brn = 1'b0;
    rdreg(0, 6'h01, "brownout", 8'h8c);
  endtask
  task automatic t_tx();
    i_host.noise();
    i_host.frame(1, 1, 24'hed0000, v);
    i_host.frame(0, 2, 24'h85aa00, v); // reserved code: no strobe, no checksum
    chk("strobes", 8'h01, n_stb[7:0]);
    chk("param", 8'h2d, {2'h0, prm});
    rdreg(0, 6'h00, "checksum", sum);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk);
    t_sum();
    t_burst();
    t_status();
    t_tx();
    close_out();
  end
  // hang guard
  initial begin
    #3000000;
    failures++;
    close_out();
  end
endmodule
